//--- core/asc_pkg.sv
package asc_pkg;

  // ****************************************************
  // System clock and serial limits
  // ****************************************************
  localparam int unsigned CLK_SYS_HZ   = 10_000_000;
  localparam int unsigned SCK_MAX_HZ   = 20_000_000;
  localparam int unsigned SYNC_STAGES  = 2;

  // ****************************************************
  // Command framing
  // ****************************************************
  localparam int unsigned CMD_BITS     = 8;
  localparam int unsigned BIT_CNT_W    = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam int unsigned RW_BIT       = 0;

  // ****************************************************
  // Clock chain
  // ****************************************************
  localparam int unsigned PRE_W        = 2;
  localparam int unsigned PRE_CNT_W    = 3;
  localparam logic [1:0]  PRE_DEFAULT  = 2'h0;
  localparam int unsigned DM_CNT_W     = 2;
  localparam logic [1:0]  DIGITAL_MASTER_CLOCK_LAST   = 2'h3;
  localparam int unsigned OSR_CODE_W   = 3;
  localparam int unsigned OSR_CNT_W    = 12;
  localparam logic [3:0]  OSR_BASE_SH  = 4'h5;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [4:0]  PIN_SYNC_RST = 5'h08;
  localparam logic [5:0]  CFG_SYNC_RST = 6'h00;
  localparam logic        BIAS_RST     = 1'h1;
  localparam logic        POWER_RST    = 1'h1;

  // ****************************************************
  // Serial port states
  // ****************************************************
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_CMD,
    ASC_WRITE,
    ASC_READ
  } asc_spiState_t;

endpackage

//--- core/asc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sync
  import asc_pkg::*;
#(
  parameter int unsigned WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  // Two-stage chain, first stage read only by second
  always_comb begin
    stage1_next = asyncIn;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
    end else if (clkEn) begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign syncOut = stage2_reg;

endmodule
`default_nettype wire

//--- core/asc_front.sv
`timescale 1ns/1ps
`default_nettype none
module asc_front
  import asc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  clkEn,
  input  wire logic                  masterReset_b,
  input  wire logic                  csPin_b,
  input  wire logic                  sckPin,
  input  wire logic                  sdiPin,
  input  wire logic                  oscInPin,
  input  wire logic                  extClockSelect,
  input  wire logic [PRE_W-1:0]      prescaleSel,
  input  wire logic [OSR_CODE_W-1:0] oversampleRatio,
  input  wire logic                  shutdownReq,
  input  wire logic [CMD_BITS-1:0]   readData,
  output logic                       sdoOut,
  output logic                       sdoOe,
  output logic                       oscOutPin,
  output logic                       oscOutOe,
  output logic                       oscEnable,
  output logic                       analogMasterClock,
  output logic                       digitalMasterClock,
  output logic                       outputRateClock,
  output logic                       convDoneStrobe,
  output logic [CMD_BITS-1:0]        cmdByte,
  output logic                       cmdValid,
  output logic                       cmdIsRead,
  output logic [CMD_BITS-1:0]        wrByte,
  output logic                       wrValid,
  output logic                       readTake,
  output logic                       biasEnable,
  output logic                       adcPowered
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [4:0]            pinSync;
  logic [5:0]            cfgSync;
  logic                  mrstS, csS, sckS, sdiS, oscS, extS;
  logic [PRE_W-1:0]      preS;
  logic [OSR_CODE_W-1:0] osrS;

  // Pins cross in through two flops
  asc_sync #(.WIDTH(5), .RST_VAL(PIN_SYNC_RST)) u_pinSync (
    .clk_sys (clk_sys), .rst_b (rst_b), .clkEn (clkEn),
    .asyncIn ({masterReset_b, csPin_b, sckPin, sdiPin, oscInPin}),
    .syncOut (pinSync)
  );

  // Clock settings cross before reaching the divider chain
  asc_sync #(.WIDTH(6), .RST_VAL(CFG_SYNC_RST)) u_cfgSync (
    .clk_sys (clk_sys), .rst_b (rst_b), .clkEn (clkEn),
    .asyncIn ({extClockSelect, prescaleSel, oversampleRatio}),
    .syncOut (cfgSync)
  );

  assign {mrstS, csS, sckS, sdiS, oscS} = pinSync;
  assign {extS, preS, osrS}             = cfgSync;

  // ****************************************************
  // Serial port
  // ****************************************************
  asc_spiState_t         state_reg,   state_next;
  logic [BIT_CNT_W-1:0]  bitCnt_reg,  bitCnt_next;
  logic [CMD_BITS-1:0]   rxShift_reg, rxShift_next;
  logic [CMD_BITS-1:0]   txShift_reg, txShift_next;
  logic [CMD_BITS-1:0]   cmdByte_reg, cmdByte_next;
  logic [CMD_BITS-1:0]   wrByte_reg,  wrByte_next;
  logic                  cmdValid_reg, cmdValid_next;
  logic                  cmdIsRead_reg, cmdIsRead_next;
  logic                  wrValid_reg, wrValid_next;
  logic                  readTake_reg, readTake_next;
  logic                  sdoOut_reg,  sdoOut_next;
  logic                  sdoOe_reg,   sdoOe_next;
  logic                  csQ_reg,     sckQ_reg;
  logic                  csFall,      sckRise,     sckFall;
  logic [CMD_BITS-1:0]   rxWord;

  // Edges of the synchronised serial pins
  assign csFall  = !csS && csQ_reg;
  assign sckRise = sckS && !sckQ_reg;
  assign sckFall = !sckS && sckQ_reg;
  assign rxWord  = {rxShift_reg[CMD_BITS-2:0], sdiS};

  // Next state of the serial port
  always_comb begin
    state_next     = state_reg;
    bitCnt_next    = bitCnt_reg;
    rxShift_next   = rxShift_reg;
    txShift_next   = txShift_reg;
    cmdByte_next   = cmdByte_reg;
    wrByte_next    = wrByte_reg;
    cmdIsRead_next = cmdIsRead_reg;
    sdoOut_next    = sdoOut_reg;
    sdoOe_next     = sdoOe_reg;
    cmdValid_next  = 1'b0;
    wrValid_next   = 1'b0;
    readTake_next  = 1'b0;
    if (!mrstS || csS) begin
      state_next  = ASC_IDLE;
      bitCnt_next = '0;
      sdoOe_next  = 1'b0;
      sdoOut_next = 1'b0;
    end else if (csFall) begin
      state_next   = ASC_CMD;
      bitCnt_next  = '0;
      rxShift_next = '0;
    end else begin
      case (state_reg)
        ASC_CMD: begin
          if (sckRise) begin
            rxShift_next = rxWord;
            bitCnt_next  = bitCnt_reg + 3'h1;
            if (bitCnt_reg == BIT_LAST) begin
              cmdByte_next   = rxWord;
              cmdValid_next  = 1'b1;
              cmdIsRead_next = rxWord[RW_BIT];
              state_next     = ASC_WRITE;
              if (rxWord[RW_BIT]) begin
                state_next    = ASC_READ;
                txShift_next  = readData;
                readTake_next = 1'b1;
                sdoOe_next    = 1'b1;
              end
            end
          end
        end
        ASC_WRITE: begin
          if (sckRise) begin
            rxShift_next = rxWord;
            bitCnt_next  = bitCnt_reg + 3'h1;
            if (bitCnt_reg == BIT_LAST) begin
              wrByte_next  = rxWord;
              wrValid_next = 1'b1;
            end
          end
        end
        ASC_READ: begin
          if (sckFall) begin
            sdoOut_next  = txShift_reg[CMD_BITS-1];
            bitCnt_next  = bitCnt_reg + 3'h1;
            txShift_next = {txShift_reg[CMD_BITS-2:0], 1'b0};
            if (bitCnt_reg == BIT_LAST) begin
              txShift_next  = readData;
              readTake_next = 1'b1;
            end
          end
        end
        default: begin
          state_next = ASC_IDLE;
        end
      endcase
    end
  end

  // Serial port registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg     <= ASC_IDLE;
      bitCnt_reg    <= '0;
      rxShift_reg   <= '0;
      txShift_reg   <= '0;
      cmdByte_reg   <= '0;
      wrByte_reg    <= '0;
      cmdValid_reg  <= 1'b0;
      cmdIsRead_reg <= 1'b0;
      wrValid_reg   <= 1'b0;
      readTake_reg  <= 1'b0;
      sdoOut_reg    <= 1'b0;
      sdoOe_reg     <= 1'b0;
      csQ_reg       <= 1'b1;
      sckQ_reg      <= 1'b0;
    end else if (clkEn) begin
      state_reg     <= state_next;
      bitCnt_reg    <= bitCnt_next;
      rxShift_reg   <= rxShift_next;
      txShift_reg   <= txShift_next;
      cmdByte_reg   <= cmdByte_next;
      wrByte_reg    <= wrByte_next;
      cmdValid_reg  <= cmdValid_next;
      cmdIsRead_reg <= cmdIsRead_next;
      wrValid_reg   <= wrValid_next;
      readTake_reg  <= readTake_next;
      sdoOut_reg    <= sdoOut_next;
      sdoOe_reg     <= sdoOe_next;
      csQ_reg       <= csS;
      sckQ_reg      <= sckS;
    end
  end

  // ****************************************************
  // Clock source, prescaler and rate chain
  // ****************************************************
  logic [PRE_CNT_W-1:0]  preCnt_reg,  preCnt_next;
  logic [DM_CNT_W-1:0]   amCnt_reg,   amCnt_next;
  logic [OSR_CNT_W-1:0]  osrCnt_reg,  osrCnt_next;
  logic                  amTick_reg,  amTick_next;
  logic                  dmTick_reg,  dmTick_next;
  logic                  rateTick_reg, rateTick_next;
  logic                  oscQ_reg,    mclkRise;
  logic                  oscOut_reg,  oscOut_next;
  logic                  oscOe_reg,   oscOe_next;
  logic                  bias_reg,    bias_next;
  logic                  power_reg,   power_next;
  logic [PRE_CNT_W-1:0]  preLimit;
  logic [OSR_CNT_W:0]    osrSpan;
  logic [OSR_CNT_W-1:0]  osrLimit;

  // Divide limits: 1/2/4/8 and ratio 32 shl code
  assign mclkRise = oscS && !oscQ_reg;
  assign preLimit = PRE_CNT_W'((4'h1 << preS) - 4'h1);
  assign osrSpan  = 13'h0001 << (OSR_BASE_SH + 4'(osrS));
  assign osrLimit = OSR_CNT_W'(osrSpan - 13'h0001);

  // Next state of the clock chain
  always_comb begin
    preCnt_next   = preCnt_reg;
    amCnt_next    = amCnt_reg;
    osrCnt_next   = osrCnt_reg;
    amTick_next   = 1'b0;
    dmTick_next   = 1'b0;
    rateTick_next = 1'b0;
    oscOe_next    = !extS;
    oscOut_next   = !extS && !oscS;
    bias_next     = BIAS_RST;
    power_next    = !shutdownReq;
    if (!mrstS) begin
      preCnt_next = '0;
      amCnt_next  = '0;
      osrCnt_next = '0;
      power_next  = POWER_RST;
    end else begin
      if (mclkRise) begin
        preCnt_next = preCnt_reg + 3'h1;
        if (preCnt_reg >= preLimit) begin
          preCnt_next = '0;
          amTick_next = 1'b1;
        end
      end
      if (amTick_reg) begin
        amCnt_next = amCnt_reg + 2'h1;
        if (amCnt_reg == DIGITAL_MASTER_CLOCK_LAST) begin
          amCnt_next  = '0;
          dmTick_next = 1'b1;
        end
      end
      if (dmTick_reg) begin
        osrCnt_next = osrCnt_reg + 12'h001;
        if (osrCnt_reg >= osrLimit) begin
          osrCnt_next   = '0;
          rateTick_next = 1'b1;
        end
      end
    end
  end

  // Clock chain registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      preCnt_reg   <= '0;
      amCnt_reg    <= '0;
      osrCnt_reg   <= '0;
      amTick_reg   <= 1'b0;
      dmTick_reg   <= 1'b0;
      rateTick_reg <= 1'b0;
      oscQ_reg     <= 1'b0;
      oscOut_reg   <= 1'b0;
      oscOe_reg    <= 1'b1;
      bias_reg     <= BIAS_RST;
      power_reg    <= POWER_RST;
    end else if (clkEn) begin
      preCnt_reg   <= preCnt_next;
      amCnt_reg    <= amCnt_next;
      osrCnt_reg   <= osrCnt_next;
      amTick_reg   <= amTick_next;
      dmTick_reg   <= dmTick_next;
      rateTick_reg <= rateTick_next;
      oscQ_reg     <= oscS;
      oscOut_reg   <= oscOut_next;
      oscOe_reg    <= oscOe_next;
      bias_reg     <= bias_next;
      power_reg    <= power_next;
    end
  end

  // Outputs straight from their registers
  assign {sdoOut, sdoOe, oscOutPin, oscOutOe, oscEnable} =
    {sdoOut_reg, sdoOe_reg, oscOut_reg, oscOe_reg, oscOe_reg};
  assign {analogMasterClock, digitalMasterClock, outputRateClock} =
    {amTick_reg, dmTick_reg, rateTick_reg};
  assign {convDoneStrobe, cmdByte, cmdValid, cmdIsRead} =
    {rateTick_reg, cmdByte_reg, cmdValid_reg, cmdIsRead_reg};
  assign {wrByte, wrValid, readTake, biasEnable, adcPowered} =
    {wrByte_reg, wrValid_reg, readTake_reg, bias_reg, power_reg};

  // ****************************************************
  // Assertions
  // ****************************************************
  a_sdo_cs_idle: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn) csS |=> !sdoOe_reg)
    else $error("output driven while select high");
  a_sdo_in_reset: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    !mrstS |=> !sdoOe_reg && state_reg == ASC_IDLE && !cmdValid_reg)
    else $error("serial activity during master reset");
  a_cmd_eighth_bit: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    cmdValid_reg |-> $past(bitCnt_reg) == BIT_LAST && $past(sckRise)
      && $past(state_reg) == ASC_CMD)
    else $error("command not closed on eighth rising edge");
  a_read_no_input: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    state_reg == ASC_READ && !csS && !csFall && mrstS
      |=> $stable(rxShift_reg) && !wrValid_reg)
    else $error("input shifted during read");
  a_cs_fall_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    csFall && mrstS |=> bitCnt_reg == '0 && state_reg == ASC_CMD)
    else $error("bit counter not cleared on select fall");
  a_div_by_one: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    mrstS && preS == PRE_DEFAULT && mclkRise |=> amTick_reg)
    else $error("undivided analog clock missed a master edge");
  a_dm_four: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    dmTick_reg |-> $past(amTick_reg) && $past(amCnt_reg) == DIGITAL_MASTER_CLOCK_LAST)
    else $error("digital clock not every fourth analog tick");
  a_rate_done: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    rateTick_reg |-> convDoneStrobe && $past(dmTick_reg)
      && $past(osrCnt_reg) >= $past(osrLimit))
    else $error("rate tick without full ratio of samples");
  a_reset_defaults: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    !mrstS |=> !amTick_reg && !dmTick_reg && power_reg && bias_reg)
    else $error("derived clocks or defaults wrong in reset");
  a_osc_select: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !clkEn)
    extS |=> !oscOe_reg && !oscOut_reg)
    else $error("oscillator driven with direct clock selected");

endmodule
`default_nettype wire

//--- dv/asc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input  wire logic clk_sys,
  input  wire logic sdoOut,
  input  wire logic sdoOe,
  output var  logic csPin_b,
  output var  logic sckPin,
  output var  logic sdiPin
);
  // ****************
  // Line state
  // ****************
  logic patReg;
  logic sdoLine;

  // Deselected host at start
  initial begin
    csPin_b = 1'h1;
    sckPin = 1'h0;
    sdiPin = 1'h0;
    patReg = 1'h0;
  end

  // Released output line shows a changing pattern
  always @(posedge clk_sys) begin
    patReg <= ~patReg;
  end
  assign sdoLine = sdoOe ? sdoOut : patReg;

  // ****************
  // Frame tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One framed transfer, bits sent MSB first from tx[23]; after the command, sdi toggles instead when tx[16] is set
  task automatic xfer(input logic cpol, input logic [23:0] tx,
                      input int nBits, output logic [23:0] rx,
                      output int oeCmd, output int oeData);
    int i;
    rx = 24'h00_0000;
    oeCmd = 0;
    oeData = 0;
    @(posedge clk_sys);
    sckPin <= cpol;        // Mode level set while deselected
    cyc(3);
    csPin_b <= 1'h0;       // Frame opens on select fall
    cyc(6);
    for (i = 0; i < nBits; i++) begin
      sckPin <= 1'h0;      // Drive on falling clock
      sdiPin <= (i >= 8 && tx[16]) ? ~sdiPin : tx[23 - i];
      cyc(6);
      rx = {rx[22:0], sdoLine}; // Sample before rising clock
      if (i < 8) begin
        oeCmd += int'(sdoOe);
      end else begin
        oeData += int'(sdoOe);
      end
      sckPin <= 1'h1;
      cyc(6);
    end
    sckPin <= cpol;        // Clock parked between frames
    cyc(6);
    csPin_b <= 1'h1;       // Frame closes on select rise
    sdiPin <= ~sdiPin;
    cyc(6);
  endtask

  // Clock and data activity while deselected
  task automatic wiggle(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      sckPin <= ~sckPin;
      sdiPin <= ~sdiPin;
      cyc(4);
    end
  endtask
endmodule
`default_nettype wire

//--- dv/afe_spi_clock_reset_front_test.sv
`timescale 1ns/1ps
`default_nettype none
module afe_spi_clock_reset_front_test;
  // ****************
  // Bench signals
  // ****************
  logic        clk_sys;
  logic        rst_b;
  logic        masterReset_b;
  logic        oscInPin;
  logic        oscDiv;
  logic        extClockSelect;
  logic [1:0]  prescaleSel;
  logic [2:0]  oversampleRatio;
  logic        shutdownReq;
  logic [7:0]  readData;
  logic        csPin_b;
  logic        sckPin;
  logic        sdiPin;
  logic        sdoOut;
  logic        sdoOe;
  logic        oscOutOe;
  logic        oscEnable;
  logic        oscOut;
  logic [2:0]  ticks;
  logic        convDoneStrobe;
  logic [7:0]  cmdByte;
  logic        cmdValid;
  logic        cmdIsRead;
  logic [7:0]  wrByte;
  logic        wrValid;
  logic        readTake;
  logic        biasEnable;
  logic        adcPowered;
  logic [7:0]  rdBytes [0:3];
  logic [7:0]  wrQ [$];
  int          rdIdx;
  int          cmdCnt;
  int          amCnt;
  int          error_cnt;
  int          total_checks;

  // Block under test
  asc_front dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'h1),
    .masterReset_b(masterReset_b), .csPin_b(csPin_b), .sckPin(sckPin),
    .sdiPin(sdiPin), .oscInPin(oscInPin), .extClockSelect(extClockSelect),
    .prescaleSel(prescaleSel), .oversampleRatio(oversampleRatio),
    .shutdownReq(shutdownReq), .readData(readData), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .oscOutPin(oscOut), .oscOutOe(oscOutOe),
    .oscEnable(oscEnable), .analogMasterClock(ticks[0]),
    .digitalMasterClock(ticks[1]), .outputRateClock(ticks[2]),
    .convDoneStrobe(convDoneStrobe), .cmdByte(cmdByte),
    .cmdValid(cmdValid), .cmdIsRead(cmdIsRead), .wrByte(wrByte),
    .wrValid(wrValid), .readTake(readTake), .biasEnable(biasEnable),
    .adcPowered(adcPowered)
  );

  // Serial master on the far side
  asc_host_model host (
    .clk_sys(clk_sys), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .csPin_b(csPin_b), .sckPin(sckPin), .sdiPin(sdiPin)
  );

  // 10 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Master clock pin, four system cycles a period
  always @(posedge clk_sys) begin
    oscDiv <= ~oscDiv;
    if (oscDiv === 1'h1) oscInPin <= ~oscInPin;
  end

  // Event capture and read byte supply
  always @(posedge clk_sys) begin
    if (cmdValid === 1'h1) cmdCnt++;
    if (wrValid === 1'h1) wrQ.push_back(wrByte);
    if (ticks[0] === 1'h1) amCnt++;
    if (readTake === 1'h1) begin
      readData <= rdBytes[rdIdx[1:0]];
      rdIdx++;
    end
    if ((ticks[2] | convDoneStrobe) === 1'h1)
      check("convDone", convDoneStrobe, ticks[2]);
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Spacing between the second and third pulse of one tick output
  task automatic gap(input int idx, input int exp, input string nm);
    int n;
    int g;
    n = 0;
    g = 0;
    while (n < 3 && g < 70000) begin
      @(posedge clk_sys);
      g++;
      if (ticks[idx] === 1'h1) begin
        n++;
        if (n < 3) g = 0;
      end
    end
    if (n < 3) begin
      error_cnt++;
      $display("mismatch %s timeout", nm);
      report_and_stop();
    end
    check(nm, g, exp);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check("bias", biasEnable, 1'h1);
    check("power", adcPowered, 1'h1);
    check("sdoOe", sdoOe, 1'h0);
    check("oscOe", oscOutOe, 1'h1);
    check("rstTick", amCnt, 0);
    rst_b <= 1'h1;
    cyc(6);
  endtask

  task automatic t_frames();
    logic [23:0] rx;
    int oc;
    int od;
    int m;
    for (m = 0; m < 2; m++) begin
      wrQ.delete();
      host.xfer(m[0], {8'ha6, 8'h5a, 8'h3c}, 24, rx, oc, od);
      check("cmdByte", cmdByte, 8'ha6);
      check("isWrite", cmdIsRead, 1'h0);
      check("wrCnt", wrQ.size(), 2);
      check("wr0", wrQ[0], 8'h5a);
      check("wr1", wrQ[1], 8'h3c);
      check("oeCmd", oc, 0);
      check("oeWr", od, 0);
      rdIdx = 1;
      readData <= rdBytes[0];
      host.xfer(m[0], {8'h41, 16'h0000}, 24, rx, oc, od);
      check("isRead", cmdIsRead, 1'h1);
      check("rdData", rx[15:0], {rdBytes[0], rdBytes[1]});
      check("oeCmdRd", oc, 0);
      check("oeRd", od, 16);
      check("sdiIgn", wrQ.size(), 2);
      check("oeIdle", sdoOe, 1'h0);
    end
  endtask

  task automatic t_abort();
    logic [23:0] rx;
    int oc;
    int od;
    host.xfer(1'h0, {8'hff, 16'h0000}, 3, rx, oc, od);
    wrQ.delete();
    host.xfer(1'h0, {8'h12, 8'h34, 8'hc0}, 20, rx, oc, od);
    check("cmdAbort", cmdByte, 8'h12);
    check("partial", wrQ.size(), 1);
    check("wrA", wrQ[0], 8'h34);
  endtask

  task automatic t_idle();
    int c;
    c = cmdCnt;
    host.wiggle(20);
    check("idleCmd", cmdCnt, c);
    check("idleWr", wrQ.size(), 1);
  endtask

  task automatic t_master_reset();
    logic [23:0] rx;
    int oc;
    int od;
    int c;
    int a;
    masterReset_b <= 1'h0;
    shutdownReq <= 1'h1;
    cyc(4);
    c = cmdCnt;
    a = amCnt;
    host.xfer(1'h0, {8'h41, 16'h0000}, 24, rx, oc, od);
    check("rstCmd", cmdCnt, c);
    check("rstOe", oc + od, 0);
    check("rstClk", amCnt, a);
    check("rstPower", adcPowered, 1'h1);
    check("rstBias", biasEnable, 1'h1);
    masterReset_b <= 1'h1;
    cyc(5);
    check("shutdown", adcPowered, 1'h0);
    shutdownReq <= 1'h0;
    cyc(3);
    check("powerOn", adcPowered, 1'h1);
    check("runAfter", amCnt != a, 1'h1);
  endtask

  task automatic t_clocks();
    int p;
    logic o;
    for (p = 0; p < 4; p++) begin
      prescaleSel <= p[1:0];  // Host picks the division
      gap(0, 4 << p, "analog_master_clock");
    end
    gap(1, 128, "digital_master_clock");
    prescaleSel <= 2'h0;
    for (p = 0; p < 2; p++) begin
      oversampleRatio <= p[2:0];
      gap(2, 512 << p, "output_rate_clock");
    end
    extClockSelect <= 1'h1;
    cyc(4);
    check("oscOff", {oscOutOe, oscEnable, oscOut}, 3'h0);
    gap(0, 4, "extClk");
    extClockSelect <= 1'h0;
    cyc(4);
    check("oscOn", {oscOutOe, oscEnable}, 2'h3);
    o = oscOut;
    cyc(2);
    check("oscDrive", oscOut, !o);
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    total_checks = 0;
    cmdCnt = 0;
    amCnt = 0;
    rdIdx = 0;
    rdBytes = '{8'hc3, 8'h96, 8'h0f, 8'hf0};
    rst_b = 1'h0;
    masterReset_b = 1'h1;
    oscInPin = 1'h0;
    oscDiv = 1'h0;
    extClockSelect = 1'h0;
    prescaleSel = 2'h0;
    oversampleRatio = 3'h0;
    shutdownReq = 1'h0;
    readData = 8'h00;
    cyc(3);
    t_reset();
    t_frames();
    t_abort();
    t_idle();
    t_master_reset();
    t_clocks();
    report_and_stop();
  end
endmodule
`default_nettype wire
